// >>> rtl/bmc_card.sv
// Decode and control logic of the banked memory card.
`timescale 1ns/100ps
`default_nettype none
module bmc_card #(
   parameter bit USER_TABLE = 1'b0
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic bus_clock_n,
   input wire logic [bmc_pkg::ADDR_W-1:0] addr,
   input wire logic [bmc_pkg::DATA_W-1:0] data_in,
   output logic [bmc_pkg::DATA_W-1:0] data_out,
   output logic data_oe_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic memory_request_line_n,
   input wire logic io_request_line_n,
   output logic wait_request_line_n,
   input wire logic [bmc_pkg::DATA_W-1:0] socket_rdata,
   output logic [bmc_pkg::NUM_SOCKETS-1:0] socket_sel_n,
   output logic [bmc_pkg::PAGE_LSB-1:0] socket_addr,
   output logic socket_oe_n,
   output logic socket_we_n,
   input wire logic reset_activity_strap,
   input wire logic [3:0] start_address_strap_n,
   input wire logic [2:0] map_select_strap,
   input wire logic [2:0] bank_select_strap,
   input wire logic common_memory_strap,
   input wire logic [7:0] port_address_strap,
   input wire logic wait_enable_strap,
   output logic bank_active
);
   // Bus inputs come from the backplane, so each passes two flops first.
   localparam int unsigned SW = 6 + bmc_pkg::ADDR_W + bmc_pkg::DATA_W;
   logic [SW-1:0] sync1_r, sync2_r;
   logic [SW-1:0] sync_in;
   assign sync_in = {bus_clock_n, rd_n, wr_n, memory_request_line_n,
      io_request_line_n, 1'b0, addr, data_in};
   always_ff @(posedge mclk) begin
      sync1_r <= sync_in;
      sync2_r <= sync1_r;
   end
   logic clk_n_s, rd_s, wr_s, mreq_s, ioreq_s;
   logic [bmc_pkg::ADDR_W-1:0] a_s;
   logic [bmc_pkg::DATA_W-1:0] d_s;
   assign clk_n_s = sync2_r[SW-1];
   assign rd_s = ~sync2_r[SW-2];
   assign wr_s = ~sync2_r[SW-3];
   assign mreq_s = ~sync2_r[SW-4];
   assign ioreq_s = ~sync2_r[SW-5];
   assign a_s = sync2_r[bmc_pkg::ADDR_W+bmc_pkg::DATA_W-1:bmc_pkg::DATA_W];
   assign d_s = sync2_r[bmc_pkg::DATA_W-1:0];
   // Straps are pins as well and pass a pair of flops of their own. A strap
   // moved while the card runs therefore takes effect two clocks later.
   localparam int unsigned TW = 21;
   logic [TW-1:0] strap1_r, strap2_r;
   always_ff @(posedge mclk) begin
      strap1_r <= {reset_activity_strap, start_address_strap_n,
         map_select_strap, bank_select_strap, common_memory_strap,
         port_address_strap, wait_enable_strap};
      strap2_r <= strap1_r;
   end
   logic rst_strap_s, common_s, wait_en_s;
   logic [3:0] start_n_s;
   logic [2:0] map_sel_s, bank_sel_s;
   logic [7:0] port_addr_s;
   assign {rst_strap_s, start_n_s, map_sel_s, bank_sel_s, common_s,
      port_addr_s, wait_en_s} = strap2_r;

   // Bank port and activity.
   logic [7:0] bank_port_r, bank_port_nxt;
   logic iowr_d_r, iowr_d_nxt;
   logic io_hit;
   assign io_hit = ioreq_s && wr_s &&
      a_s[7:0] == port_addr_s;
   always_comb begin
      bank_port_nxt = bank_port_r;
      iowr_d_nxt = io_hit;
      if (io_hit && !iowr_d_r) begin
         bank_port_nxt = d_s;
      end
   end
   logic active_c;
   logic sel_bit;
   assign sel_bit = bank_port_r[bank_sel_s];
   // A jumper on the reset strap marks this card as boot memory.
   logic reset_state_r, reset_state_nxt;
   assign reset_state_nxt = rst_strap_s;
   always_comb begin
      if (common_s) begin
         active_c = |bank_port_r || reset_state_r;
      end else begin
         active_c = sel_bit || (bank_port_r == bmc_pkg::BANK_PORT_RESET
            && reset_state_r);
      end
   end
   // Reset can't load a strap asynchronously; it is held by a clocked flop.
   always_ff @(posedge mclk) begin
      reset_state_r <= reset_state_nxt;
      if (reset) begin
         bank_port_r <= bmc_pkg::BANK_PORT_RESET;
         iowr_d_r <= 1'b0;
      end else begin
         bank_port_r <= bank_port_nxt;
         iowr_d_r <= iowr_d_nxt;
      end
   end

   // Memory decode through the lookup table.
   bmc_map_if map ();
   bmc_map_table #(.USER_TABLE(USER_TABLE)) u_table (.map(map));
   logic [3:0] start_digit;
   assign start_digit = ~start_n_s;
   logic [bmc_pkg::PAGE_W-1:0] rel_page;
   // Offset from the 4K start; wraps modulo the 64K bank.
   assign rel_page = 6'(a_s[15:10] - {start_digit, 2'h0});
   assign map.page = rel_page;
   assign map.map_sel = map_sel_s;
   logic hit;
   assign hit = mreq_s && (rd_s || wr_s) && active_c
      && map.entry.used;

   // Bus clock rising edge (bus_clock_n falling) detect on the synchronised level.
   logic clk_n_d_r;
   logic bclk_rise;
   assign bclk_rise = clk_n_d_r && !clk_n_s;

   bmc_pkg::bmc_state_e state_r, state_nxt;
   logic wait_n_r, wait_n_nxt;
   logic oe_n_r, oe_n_nxt;
   logic [bmc_pkg::NUM_SOCKETS-1:0] sel_n_r, sel_n_nxt;
   logic [bmc_pkg::DATA_W-1:0] dout_r, dout_nxt;
   logic [bmc_pkg::PAGE_LSB-1:0] saddr_r, saddr_nxt;
   logic soe_n_r, soe_n_nxt, swe_n_r, swe_n_nxt;
   always_comb begin
      state_nxt = state_r;
      wait_n_nxt = 1'b1;
      oe_n_nxt = 1'b1;
      sel_n_nxt = '1;
      dout_nxt = dout_r;
      saddr_nxt = a_s[bmc_pkg::PAGE_LSB-1:0];
      soe_n_nxt = 1'b1;
      swe_n_nxt = 1'b1;
      case (state_r)
         bmc_pkg::BMC_IDLE: begin
            if (hit) begin
               if (wait_en_s && map.entry.slow) begin
                  state_nxt = bmc_pkg::BMC_WAIT;
               end else begin
                  state_nxt = bmc_pkg::BMC_ACCESS;
               end
            end
         end
         bmc_pkg::BMC_WAIT: begin
            // An aborted cycle must not leave the wait request hanging.
            wait_n_nxt = ~hit;
            if (!hit) begin
               state_nxt = bmc_pkg::BMC_IDLE;
            end else if (bclk_rise) begin
               state_nxt = bmc_pkg::BMC_ACCESS;
            end
         end
         default: begin
            if (!hit) begin
               state_nxt = bmc_pkg::BMC_IDLE;
            end
         end
      endcase
      if (hit) begin
         sel_n_nxt[map.entry.socket] = 1'b0;
         soe_n_nxt = ~rd_s;
         swe_n_nxt = ~wr_s;
         if (rd_s) begin
            oe_n_nxt = 1'b0;
            dout_nxt = socket_rdata;
         end
      end
   end
   always_ff @(posedge mclk) begin
      if (reset) begin
         state_r <= bmc_pkg::BMC_IDLE;
         wait_n_r <= 1'b1;
         oe_n_r <= 1'b1;
         sel_n_r <= '1;
         dout_r <= '0;
         saddr_r <= '0;
         soe_n_r <= 1'b1;
         swe_n_r <= 1'b1;
         clk_n_d_r <= 1'b1;
         bank_active <= 1'b0;
      end else begin
         state_r <= state_nxt;
         wait_n_r <= wait_n_nxt;
         oe_n_r <= oe_n_nxt;
         sel_n_r <= sel_n_nxt;
         dout_r <= dout_nxt;
         saddr_r <= saddr_nxt;
         soe_n_r <= soe_n_nxt;
         swe_n_r <= swe_n_nxt;
         clk_n_d_r <= clk_n_s;
         bank_active <= active_c;
      end
   end
   // No interrupt outputs exist on this card at all.
   assign wait_request_line_n = wait_n_r;
   assign data_oe_n = oe_n_r;
   assign data_out = dout_r;
   assign socket_sel_n = sel_n_r;
   assign socket_addr = saddr_r;
   assign socket_oe_n = soe_n_r;
   assign socket_we_n = swe_n_r;
endmodule : bmc_card
`default_nettype wire

// >>> rtl/bmc_map_table.sv
// Socket lookup table: preset layouts or a user-programmed table.
`timescale 1ns/100ps
`default_nettype none
module bmc_map_table #(
   parameter bit USER_TABLE = 1'b0,
   parameter bmc_pkg::bmc_entry_s USER_MAP [64] = '{default: '0}
) (
   bmc_map_if.table_side map
);
   function automatic bmc_pkg::bmc_entry_s ent(input logic [2:0] s,
         input logic sl);
      ent = '{used: 1'b1, slow: sl, socket: s};
   endfunction : ent

   // Page is 1K within the 64K bank.
   function automatic bmc_pkg::bmc_entry_s preset(input logic [2:0] m,
         input logic [5:0] p);
      preset = '0;
      case (m)
         3'h0: if (p < 6'h08) preset = ent(p[2:0], 1'b0);
         3'h1: if (p < 6'h10) preset = ent(p[3:1], 1'b1);
         3'h2: if (p < 6'h20) preset = ent(p[4:2], 1'b1);
         3'h3: begin
            if (p < 6'h20) preset = ent({1'b0, p[4:3]}, 1'b1);
            else if (p < 6'h28) preset = ent({1'b1, p[2:1]}, 1'b0);
         end
         3'h4: begin
            if (p < 6'h20) preset = ent({2'h0, p[4]}, 1'b1);
            else if (p < 6'h2c) preset = ent(3'(p[3:1] + 3'h2), 1'b0);
         end
         3'h5: begin
            if (p < 6'h20) preset = ent(3'h0, 1'b1);
            else if (p < 6'h2e) preset = ent(3'(p[3:1] + 3'h1), 1'b0);
         end
         3'h6: begin
            if (p < 6'h20) preset = ent(3'h0, 1'b1);
            else if (p < 6'h26) preset = ent(3'(p[2:1] + 3'h1), 1'b1);
            else if (p < 6'h2c) preset = ent(3'(p[3:1] + 3'h1), 1'b0);
            else if (p >= 6'h3e) preset = ent(3'h7, 1'b0);
         end
         default: begin
            if (p < 6'h18) preset = ent({1'b0, p[4:3]}, 1'b1);
            else if (p >= 6'h20 && p < 6'h24) preset =
               ent(3'(p[1] + 3'h3), 1'b1);
            else if (p >= 6'h24 && p < 6'h28) preset =
               ent(3'(p[1] + 3'h5), 1'b0);
            else if (p >= 6'h3e) preset = ent(3'h7, 1'b0);
         end
      endcase
   endfunction : preset

   always_comb begin
      if (USER_TABLE) begin
         map.entry = USER_MAP[map.page];
      end else begin
         map.entry = preset(map.map_sel, map.page);
      end
   end
endmodule : bmc_map_table
`default_nettype wire

// >>> shared/bmc_map_if.sv
// Interface between the decoder core and its socket lookup table.
`timescale 1ns/100ps
`default_nettype none
interface bmc_map_if;
   logic [2:0] map_sel;
   logic [bmc_pkg::PAGE_W-1:0] page;
   bmc_pkg::bmc_entry_s entry;
   modport core (output map_sel, output page, input entry);
   modport table_side (input map_sel, input page, output entry);
endinterface : bmc_map_if
`default_nettype wire

// >>> shared/bmc_pkg.sv
// Package of constants and types for the banked memory card decoder.
package bmc_pkg;
   localparam int unsigned NUM_SOCKETS = 8;
   localparam int unsigned NUM_BANKS = 8;
   localparam int unsigned NUM_MAPS = 8;
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned PAGE_W = 6;
   localparam int unsigned PAGE_LSB = 10;
   localparam int unsigned BLOCK_LSB = 12;
   localparam int unsigned SOCK_W = 3;
   localparam logic [7:0] BANK_PORT_RESET = 8'h00;
   localparam logic [7:0] PORT_ADDR_DEFAULT = 8'hff;
   localparam logic [2:0] MAP_SEL_DEFAULT = 3'h7;
   localparam logic [3:0] START_DEFAULT = 4'h0;
   localparam int unsigned WAIT_STATES = 1;
   localparam int unsigned CLK_PERIOD_NS = 25;
   localparam int unsigned BUS_CLK_NS = 250;
   localparam int unsigned WAIT_CYCLES =
      (WAIT_STATES * BUS_CLK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   typedef struct packed {
      logic used;
      logic slow;
      logic [SOCK_W-1:0] socket;
   } bmc_entry_s;
   typedef enum logic [1:0] {
      BMC_IDLE,
      BMC_WAIT,
      BMC_ACCESS
   } bmc_state_e;
endpackage : bmc_pkg

// >>> test/banked_memory_card_decoder_bench.sv
// Directed testbench for the banked memory card decoder.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin total_checks++; if ((e) !== (s)) begin \
   num_errors++; $display("wrong value %s expected %h seen %h", n, e, s); \
   end end
module banked_memory_card_decoder_bench;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic bus_clock_n, data_oe_n, rd_n, wr_n, socket_oe_n, socket_we_n;
   logic memory_request_line_n, io_request_line_n, wait_request_line_n;
   logic [15:0] addr;
   logic [7:0] data_in, data_out, socket_rdata, socket_sel_n;
   logic [9:0] socket_addr;
   logic [7:0] port_address_strap = 8'hff;
   logic reset_activity_strap = 1'b1;
   logic [3:0] start_address_strap_n = 4'hf;
   logic [2:0] map_select_strap = 3'h7;
   logic [2:0] bank_select_strap = 3'h0;
   logic common_memory_strap = 1'b0;
   logic wait_enable_strap = 1'b1;
   logic bank_active, oe, wt;
   logic [7:0] q;
   int num_errors = 0;
   int total_checks = 0;
   int cycles = 0;
   int b;
   // Each socket returns a one-hot byte naming itself.
   assign socket_rdata = ~socket_sel_n;
   bmc_card uut (.*);
   bmc_host_model host (.*);
   initial begin
      forever #12.5 mclk = ~mclk;
   end
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : report_and_stop
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 6000) begin
         num_errors++;
         report_and_stop();
      end
   end
   task automatic rd(input logic [15:0] a, input logic eo,
      input logic [7:0] ed, input logic ew);
      host.access(1'b1, 1'b1, a, 8'h00, q, oe, wt);
      `CHK("read oe", eo, oe)
      if (eo) `CHK("read data", ed, q)
      `CHK("read wait", ew, wt)
   endtask : rd
   task automatic io(input logic [15:0] a, input logic [7:0] d);
      host.access(1'b0, 1'b0, a, d, q, oe, wt);
   endtask : io
   task automatic pulse_reset();
      reset = 1'b1;
      repeat (6) @(negedge mclk);
      reset = 1'b0;
      repeat (3) @(negedge mclk);
   endtask : pulse_reset
   initial begin
      pulse_reset();
      `CHK("active", 1'b1, bank_active)
      rd(16'h0000, 1'b1, 8'h01, 1'b1);
      rd(16'h8000, 1'b1, 8'h08, 1'b1);
      rd(16'h9000, 1'b1, 8'h20, 1'b0);
      rd(16'hf800, 1'b1, 8'h80, 1'b0);
      rd(16'hf000, 1'b0, 8'h00, 1'b0);
      wait_enable_strap = 1'b0;
      rd(16'h0000, 1'b1, 8'h01, 1'b0);
      wait_enable_strap = 1'b1;
      host.access(1'b1, 1'b0, 16'h8000, 8'h5a, q, oe, wt);
      `CHK("write oe", 1'b0, oe)
      `CHK("write wait", 1'b1, wt)
      $display("test 1 finished");
      start_address_strap_n = 4'hd;
      rd(16'h2000, 1'b1, 8'h01, 1'b1);
      rd(16'h1000, 1'b0, 8'h00, 1'b0);
      rd(16'hb000, 1'b1, 8'h20, 1'b0);
      start_address_strap_n = 4'hf;
      map_select_strap = 3'h0;
      rd(16'h0400, 1'b1, 8'h02, 1'b0);
      rd(16'h1400, 1'b1, 8'h20, 1'b0);
      map_select_strap = 3'h7;
      $display("test 2 finished");
      port_address_strap = 8'h5a;
      io(16'h00ff, 8'h01);
      `CHK("active", 1'b1, bank_active)
      io(16'h125a, 8'h02);
      `CHK("active", 1'b0, bank_active)
      port_address_strap = 8'hff;
      rd(16'h0000, 1'b0, 8'h00, 1'b0);
      for (b = 0; b < 8; b++) begin
         bank_select_strap = b[2:0];
         io(16'h00ff, 8'h01 << b);
         `CHK("bank on", 1'b1, bank_active)
         io(16'h00ff, ~(8'h01 << b));
         `CHK("bank off", 1'b0, bank_active)
      end
      common_memory_strap = 1'b1;
      rd(16'h0000, 1'b1, 8'h01, 1'b1);
      common_memory_strap = 1'b0;
      bank_select_strap = 3'h0;
      $display("test 3 finished");
      reset_activity_strap = 1'b0;
      pulse_reset();
      `CHK("active", 1'b0, bank_active)
      io(16'h00ff, 8'h01);
      `CHK("active", 1'b1, bank_active)
      $display("test 4 finished");
      report_and_stop();
   end
endmodule : banked_memory_card_decoder_bench
`default_nettype wire

// >>> test/bmc_card_checker.sv
// Port-level assertions for the banked memory card decoder.
`timescale 1ns/100ps
`default_nettype none
module bmc_card_checker (
   input wire logic mclk,
   input wire logic reset,
   input wire logic [15:0] addr,
   input wire logic [7:0] data_out,
   input wire logic data_oe_n,
   input wire logic wait_request_line_n,
   input wire logic [7:0] socket_rdata,
   input wire logic [7:0] socket_sel_n,
   input wire logic [9:0] socket_addr,
   input wire logic socket_oe_n,
   input wire logic socket_we_n,
   input wire logic reset_activity_strap,
   input wire logic wait_enable_strap,
   input wire logic bank_active
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   oe_read_only_a: assert property (
      !data_oe_n |-> !socket_oe_n && socket_we_n)
      else $error("data bus driven outside a socket read");
   one_socket_a: assert property (
      socket_sel_n != 8'hff |-> $onehot(~socket_sel_n))
      else $error("more than one socket selected");
   inactive_quiet_a: assert property (
      !bank_active |-> data_oe_n && socket_sel_n == 8'hff)
      else $error("inactive card answered");
   wait_slow_only_a: assert property (
      !wait_request_line_n |-> wait_enable_strap && socket_sel_n != 8'hff)
      else $error("wait request without a slow socket access");
   wait_bounded_a: assert property (
      $fell(wait_request_line_n) |-> ##[1:16] wait_request_line_n)
      else $error("wait request held too long");
   reset_state_a: assert property (
      $fell(reset) |-> ##[0:2] bank_active == reset_activity_strap)
      else $error("activity after reset differs from strap");
   data_follow_a: assert property (
      !data_oe_n && !$past(data_oe_n) |-> data_out == $past(socket_rdata))
      else $error("read data does not follow the socket");
   socket_addr_a: assert property (
      socket_sel_n != 8'hff |-> socket_addr == $past(addr[9:0], 3))
      else $error("socket address differs from bus address");
   write_strobe_a: assert property (
      !socket_we_n |-> socket_oe_n && data_oe_n && socket_sel_n != 8'hff)
      else $error("socket write strobe outside a selected write");
endmodule : bmc_card_checker
bind bmc_card bmc_card_checker chk (.*);
`default_nettype wire

// >>> test/bmc_host_model.sv
// Behavioural backplane host running memory and I/O cycles.
`timescale 1ns/100ps
`default_nettype none
module bmc_host_model (
   input wire logic mclk,
   output logic bus_clock_n,
   output logic [15:0] addr,
   output logic [7:0] data_in,
   output logic rd_n,
   output logic wr_n,
   output logic memory_request_line_n,
   output logic io_request_line_n,
   input wire logic [7:0] data_out,
   input wire logic data_oe_n,
   input wire logic wait_request_line_n
);
   initial begin
      {rd_n, wr_n, memory_request_line_n, io_request_line_n} = 4'hf;
      addr = 16'h0000;
      data_in = 8'h00;
      bus_clock_n = 1'b1;
      forever #125 bus_clock_n = ~bus_clock_n;
   end
   // The cycle is stretched while the card holds its wait request.
   task automatic access(input logic mem, input logic rd,
      input logic [15:0] a, input logic [7:0] d,
      output logic [7:0] q, output logic oe, output logic wt);
      int i;
      wt = 1'b0;
      @(negedge mclk);
      addr = a;
      data_in = d;
      memory_request_line_n = ~mem;
      io_request_line_n = mem;
      rd_n = ~rd;
      wr_n = rd;
      for (i = 0; i < 30 && (i < 6 || !wait_request_line_n); i++) begin
         @(negedge mclk);
         wt |= !wait_request_line_n;
      end
      @(negedge mclk);
      q = data_out;
      oe = !data_oe_n;
      {rd_n, wr_n, memory_request_line_n, io_request_line_n} = 4'hf;
      // Released lines show the inverse so stale values cannot pass.
      @(negedge mclk);
      addr = ~a;
      data_in = ~d;
      repeat (3) @(negedge mclk);
   endtask : access
endmodule : bmc_host_model
`default_nettype wire
